// ### hw/dcs_consts.svh
// Shared timing counts and pipeline positions for the burst-of-two SRAM link
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// System clock period in ns (10 MHz)
`define DCS_CLK_NS 100
// Input clock stop time that resets the DLL, in ns
`define DCS_STOP_NS 30
// Stop time in whole clock cycles, rounded up
`define DCS_STOP_CYC ((`DCS_STOP_NS + `DCS_CLK_NS - 1) / `DCS_CLK_NS)
// System clock cycles per input clock period (true edge plus complement edge)
`define DCS_K_PER_CYC 2
// Input clock cycles needed for DLL lock
`define DCS_DLL_LOCK_CYC 1024
// Power-up hold of the DLL-disable line, in cycles
`define DCS_PWR_CYC 16
// DLL reset pulse width on a frequency change, in cycles
`define DCS_DLL_RST_CYC 4
// Pipeline stage (cycles after command) of each data beat
`define DCS_WR_B1_STG 2
`define DCS_WR_B2_STG 3
`define DCS_RD_B1_STG 3
`define DCS_RD_B2_STG 4

`endif

// ### hw/dcs_pkg.sv
// Types shared by both ends of the burst-of-two SRAM link
package dcs_pkg;
   // Controller sequencing states, Gray coded along power-up path
   typedef enum logic [1:0]
   {
      DCS_ST_PWR = 2'h0,
      DCS_ST_LOCK = 2'h1,
      DCS_ST_RUN = 2'h3,
      DCS_ST_RELOCK = 2'h2
   } dcs_state_t;
endpackage

// ### hw/dcs_if.sv
// Link between the memory controller and the burst-of-two SRAM
`timescale 1ns/1ns
`default_nettype none
interface dcs_if #(
   parameter int AW = 8,
   parameter int DW = 18,
   parameter int NB = 2
)();
   logic k_rise;               // High on true input clock edge cycles
   logic c_rise;               // High on true output clock edge cycles
   logic c_tied_high;          // Output clocks unused, tied high
   logic dll_off_n;            // DLL disable, active low
   logic load_strobe_n;        // Command load, active low
   logic rw_sel;               // 1 = read, 0 = write
   logic [AW-1:0] addr_in;     // Burst base address
   logic [NB-1:0] byte_mask_n; // Lane write masks (nibble masks on x8)
   logic [DW-1:0] dq_c;        // Data driven by the controller
   logic dq_c_oe;              // Controller drives the data bus
   logic [DW-1:0] dq_d;        // Data driven by the memory
   logic dq_d_oe;              // Memory drives the data bus
   logic [DW-1:0] dq;          // Resolved bus level

   // Undriven bus reads as zero rather than floating
   assign dq = dq_d_oe ? dq_d : (dq_c_oe ? dq_c : '0);

   modport dev (
      input k_rise, c_rise, c_tied_high, dll_off_n, load_strobe_n,
      input rw_sel, addr_in, byte_mask_n, dq,
      output dq_d, dq_d_oe
   );
   modport ctrl (
      output k_rise, c_rise, c_tied_high, dll_off_n, load_strobe_n,
      output rw_sel, addr_in, byte_mask_n, dq_c, dq_c_oe,
      input dq
   );
endinterface
`default_nettype wire

// ### hw/dcs_dev.sv
// Memory end: common-I/O DDR SRAM core with burst of two
//
// Functional notes
// - each command moves exactly two beats
// - new command allowed every input clock
// - deselect pipelined like read, beats finish
// - load high ignores command, bursts complete
// - address and command sampled on true edge
// - read is load low, select high
// - read beats on complement then true edge
// - write beats follow on next true/complement
// - controller holds DLL off during power-up
// - controller waits 1024 input clock cycles after DLL enable
// - DLL reset by disable or clock stop
// - frequency change needs DLL reset and relock
// - DLL tracks the clock firing outputs
// - DLL idle while disable line low
// - high mask bit keeps that lane unchanged
// - masks free per lane, per beat
// - one address load covers two beats
// - x8 uses two nibble masks
// - x8/x9 address LSB forced to zero
// - all masks off both beats aborts write
`timescale 1ns/1ns
`default_nettype none
`include "dcs_consts.svh"
module dcs_dev
   import dcs_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 18,
   parameter int NB = 2,
   parameter int LSB_FORCED = 0,
   parameter int LOCK_CYC = `DCS_DLL_LOCK_CYC
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Link to the controller
   dcs_if.dev lnk,
   // Status
   output logic o_dll_locked,
   output logic o_wr_abort
);
   // Lane width: 9 for byte masks, 4 for nibble masks on x8
   localparam int LW = DW / NB;
   localparam int IA = AW + LSB_FORCED;
   localparam int DEPTH = 1 << IA;
   localparam int LCW = $clog2(LOCK_CYC + 1);
   localparam int KGAP = `DCS_K_PER_CYC + `DCS_STOP_CYC;
   localparam logic [IA-1:0] ADR_ONE = IA'(1);
   localparam int NS = `DCS_RD_B2_STG;

   logic [DW-1:0] mem [0:DEPTH-1]; // Storage array, not reset
   logic k_prev_reg;               // Last true input clock level
   logic c_prev_reg;               // Last true output clock level
   logic k_edge;                   // True input clock edge this cycle
   logic c_edge;                   // True output clock edge this cycle
   logic rd_cap;                   // Read command captured
   logic wr_cap;                   // Write command captured
   logic [IA-1:0] base_adr;        // Internal burst base address
   logic [NS:1] rd_pipe_reg;       // Read command age, one bit per cycle
   logic [NS:1] wr_pipe_reg;       // Write command age
   logic [IA-1:0] adr_pipe_reg [1:NS]; // Address travelling with command
   logic [DW-1:0] lane_en;         // Bits enabled by this beat's masks
   logic wr_b1;                    // First write beat on the bus
   logic wr_b2;                    // Second write beat on the bus
   logic [IA-1:0] wr_adr;          // Address of the current write beat
   logic b1_any_reg;               // Some lane stored in first beat
   logic [DW-1:0] dq_d_reg;        // Read output register
   logic dq_oe_reg;                // Read output enable
   logic [2:0] gap_reg;            // Cycles since last input clock edge
   logic dll_stop;                 // Input clock considered stopped
   logic [LCW-1:0] lock_cnt_reg;   // DLL lock progress

   ////////////////////////////////////////////////////////////////////
   // Clock edge detection; a held clock level gives no edges
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         k_prev_reg <= 1'h0;
         c_prev_reg <= 1'h0;
      end
      else
      begin
         k_prev_reg <= lnk.k_rise;
         c_prev_reg <= lnk.c_rise;
      end
   end

   assign k_edge = lnk.k_rise & ~k_prev_reg;
   assign c_edge = lnk.c_rise & ~c_prev_reg;

   ////////////////////////////////////////////////////////////////////
   // Command decode on the true edge only
   // Load high masks the select, so nothing new enters the pipe
   assign rd_cap = k_edge & ~lnk.load_strobe_n & lnk.rw_sel;
   assign wr_cap = k_edge & ~lnk.load_strobe_n & ~lnk.rw_sel;

   // Narrow variants never see the LSB; it starts every burst at zero
   generate
      if (LSB_FORCED != 0)
      begin : g_lsb0
         assign base_adr = {lnk.addr_in, 1'h0};
      end
      else
      begin : g_lsbx
         assign base_adr = lnk.addr_in;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Command pipeline, shifts every cycle so deselects age like reads
   // A captured burst always reaches both beat stages: it cannot stop
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rd_pipe_reg <= '0;
         wr_pipe_reg <= '0;
      end
      else
      begin
         rd_pipe_reg <= {rd_pipe_reg[NS-1:1], rd_cap};
         wr_pipe_reg <= {wr_pipe_reg[NS-1:1], wr_cap};
      end
   end

   // Address follows its command; only valid stages are ever used
   always_ff @(posedge i_clk)
   begin
      adr_pipe_reg[1] <= base_adr;
      for (int i = 2; i <= NS; i++)
      begin
         adr_pipe_reg[i] <= adr_pipe_reg[i-1];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write path: masks sampled with each beat, lane by lane
   generate
      for (genvar g = 0; g < NB; g++)
      begin : g_lane
         assign lane_en[g*LW +: LW] = {LW{~lnk.byte_mask_n[g]}};
      end
   endgenerate

   assign wr_b1 = wr_pipe_reg[`DCS_WR_B1_STG];
   assign wr_b2 = wr_pipe_reg[`DCS_WR_B2_STG];
   // Second beat toggles the one-bit burst counter
   assign wr_adr = wr_b1 ? adr_pipe_reg[`DCS_WR_B1_STG]
                         : (adr_pipe_reg[`DCS_WR_B2_STG] ^ ADR_ONE);

   // Read-modify-write merge keeps masked lanes undisturbed
   always_ff @(posedge i_clk)
   begin
      if ((wr_b1 || wr_b2) && (|lane_en))
      begin
         mem[wr_adr] <= (mem[wr_adr] & ~lane_en) | (lnk.dq & lane_en);
      end
   end

   // Abort flag: a pulse when neither beat stored any lane
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         b1_any_reg <= 1'h0;
         o_wr_abort <= 1'h0;
      end
      else
      begin
         if (wr_b1)
         begin
            b1_any_reg <= |lane_en;
         end
         o_wr_abort <= wr_b2 & ~b1_any_reg & ~(|lane_en);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read path: register loaded one cycle ahead of each beat
   // Output clock skew is below one cycle here, so both sources share
   // the same cycle slots; only the DLL reference differs
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         dq_d_reg <= '0;
         dq_oe_reg <= 1'h0;
      end
      else
      begin
         // First beat, complement output edge
         if (rd_pipe_reg[`DCS_RD_B1_STG - 1])
         begin
            dq_d_reg <= mem[adr_pipe_reg[`DCS_RD_B1_STG - 1]];
         end
         // Second beat, next true output edge
         else if (rd_pipe_reg[`DCS_RD_B2_STG - 1])
         begin
            dq_d_reg <= mem[adr_pipe_reg[`DCS_RD_B2_STG - 1] ^ ADR_ONE];
         end
         // Drivers only on read beats, high impedance otherwise
         dq_oe_reg <= rd_pipe_reg[`DCS_RD_B1_STG - 1]
                    | rd_pipe_reg[`DCS_RD_B2_STG - 1];
      end
   end

   assign lnk.dq_d = dq_d_reg;
   assign lnk.dq_d_oe = dq_oe_reg;

   ////////////////////////////////////////////////////////////////////
   // Input clock stop detector; normal period is two cycles
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         gap_reg <= 3'h0;
      end
      else if (k_edge)
      begin
         gap_reg <= 3'h0;
      end
      else if (!dll_stop)
      begin
         gap_reg <= gap_reg + 3'h1;
      end
   end

   assign dll_stop = (gap_reg >= 3'(KGAP));

   ////////////////////////////////////////////////////////////////////
   // DLL lock counter on the clock that fires the output registers
   // A locked indication is lost at once on disable or clock stop
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         lock_cnt_reg <= '0;
      end
      else if (!lnk.dll_off_n || dll_stop)
      begin
         lock_cnt_reg <= '0;
      end
      else if ((lnk.c_tied_high ? k_edge : c_edge)
               && (lock_cnt_reg != LCW'(LOCK_CYC)))
      begin
         lock_cnt_reg <= lock_cnt_reg + LCW'(1);
      end
   end

   // Status for the host side; relock after frequency change shows here
   assign o_dll_locked = (lock_cnt_reg == LCW'(LOCK_CYC));
endmodule
`default_nettype wire

// ### hw/dcs_ctrl.sv
// Controller end: drives clocks, commands and write data to the SRAM
`timescale 1ns/1ns
`default_nettype none
`include "dcs_consts.svh"
module dcs_ctrl
   import dcs_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 18,
   parameter int NB = 2,
   parameter int USE_C = 1,
   parameter int PWR_CYC = `DCS_PWR_CYC,
   parameter int LOCK_CYC = `DCS_DLL_LOCK_CYC,
   parameter int RST_CYC = `DCS_DLL_RST_CYC
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Request
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire logic i_req_write,
   input wire logic [AW-1:0] i_req_addr,
   input wire logic [DW-1:0] i_req_wdata0,
   input wire logic [DW-1:0] i_req_wdata1,
   input wire logic [NB-1:0] i_req_mask0_n,
   input wire logic [NB-1:0] i_req_mask1_n,
   input wire logic i_freq_change,
   // Answer
   output logic o_rd_valid,
   output logic [DW-1:0] o_rd_data0,
   output logic [DW-1:0] o_rd_data1,
   output logic o_link_up,
   // Link to the memory
   dcs_if.ctrl lnk
);
   // Sized for the power, lock and reset waits added together, the lock phase counted in clock cycles
   localparam int CW =
      $clog2(LOCK_CYC * `DCS_K_PER_CYC + PWR_CYC + RST_CYC + 1);
   localparam int NS = `DCS_RD_B2_STG;

   dcs_state_t state_reg;      // Power and DLL sequence state
   logic [CW-1:0] cnt_reg;     // Wait counter of the current state
   logic k_phase_reg;          // Generated input clock level
   logic load_n_reg;           // Registered command strobe
   logic rw_reg;               // Registered read select
   logic [AW-1:0] adr_reg;     // Registered address
   logic [DW-1:0] wd0_reg;     // First write beat held from accept
   logic [DW-1:0] wd1_reg;     // Second write beat held from accept
   logic [NB-1:0] m0_reg;      // First beat masks
   logic [NB-1:0] m1_reg;      // Second beat masks
   logic [DW-1:0] wd1_hold_reg; // Second beat, safe from a new accept
   logic [NB-1:0] m1_hold_reg; // Second beat masks, held
   logic [DW-1:0] dq_reg;      // Data on the bus
   logic [NB-1:0] mask_reg;    // Masks on the bus
   logic oe_reg;               // Controller drives the bus
   logic [NS:1] rd_pipe_reg;   // Age of issued reads
   logic [NS:1] wr_pipe_reg;   // Age of issued writes
   logic accept;               // Request taken this cycle

   ////////////////////////////////////////////////////////////////////
   // Clock generation, free running from reset so the DLL sees it
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         k_phase_reg <= 1'h0;
      end
      else
      begin
         k_phase_reg <= ~k_phase_reg;
      end
   end

   assign lnk.k_rise = k_phase_reg;
   assign lnk.c_rise = k_phase_reg;
   assign lnk.c_tied_high = (USE_C == 0);

   ////////////////////////////////////////////////////////////////////
   // Power-up and DLL sequencing
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_reg <= DCS_ST_PWR;
         cnt_reg <= '0;
      end
      else
      begin
         cnt_reg <= cnt_reg + CW'(1);
         case (state_reg)
            // DLL held off while supplies and clocks settle
            DCS_ST_PWR:
               if (cnt_reg == CW'(PWR_CYC - 1))
               begin
                  state_reg <= DCS_ST_LOCK;
                  cnt_reg <= '0;
               end
            // Lock counted in input clock periods
            DCS_ST_LOCK:
               if (cnt_reg == CW'(LOCK_CYC * `DCS_K_PER_CYC - 1))
               begin
                  state_reg <= DCS_ST_RUN;
                  cnt_reg <= '0;
               end
            // Frequency change forces a DLL reset first
            DCS_ST_RUN:
               if (i_freq_change)
               begin
                  state_reg <= DCS_ST_RELOCK;
                  cnt_reg <= '0;
               end
            DCS_ST_RELOCK:
               if (cnt_reg == CW'(RST_CYC - 1))
               begin
                  state_reg <= DCS_ST_LOCK;
                  cnt_reg <= '0;
               end
            default:
               state_reg <= DCS_ST_PWR;
         endcase
      end
   end

   assign lnk.dll_off_n = (state_reg == DCS_ST_LOCK)
                        | (state_reg == DCS_ST_RUN);
   assign o_link_up = (state_reg == DCS_ST_RUN);

   ////////////////////////////////////////////////////////////////////
   // Accept in the low phase so the command sits on the true edge
   // A write right after a read waits one input clock for turnaround
   assign o_req_ready = o_link_up & ~k_phase_reg & ~i_freq_change
                      & ~(i_req_write & rd_pipe_reg[1]);
   assign accept = i_req_valid & o_req_ready;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         load_n_reg <= 1'h1;
         rw_reg <= 1'h1;
         adr_reg <= '0;
      end
      else
      begin
         load_n_reg <= ~accept;
         if (accept)
         begin
            rw_reg <= ~i_req_write;
            adr_reg <= i_req_addr;
         end
      end
   end

   assign lnk.load_strobe_n = load_n_reg;
   assign lnk.rw_sel = rw_reg;
   assign lnk.addr_in = adr_reg;

   // Write data captured at accept
   always_ff @(posedge i_clk)
   begin
      if (accept && i_req_write)
      begin
         wd0_reg <= i_req_wdata0;
         wd1_reg <= i_req_wdata1;
         m0_reg <= i_req_mask0_n;
         m1_reg <= i_req_mask1_n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Issued command ages, one bit per cycle from the command cycle
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rd_pipe_reg <= '0;
         wr_pipe_reg <= '0;
      end
      else
      begin
         rd_pipe_reg <= {rd_pipe_reg[NS-1:1], ~load_n_reg & rw_reg};
         wr_pipe_reg <= {wr_pipe_reg[NS-1:1], ~load_n_reg & ~rw_reg};
      end
   end

   // Write beats: first on the next true edge, second on complement
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         dq_reg <= '0;
         mask_reg <= '1;
         oe_reg <= 1'h0;
         wd1_hold_reg <= '0;
         m1_hold_reg <= '1;
      end
      else
      begin
         if (wr_pipe_reg[`DCS_WR_B1_STG - 1])
         begin
            dq_reg <= wd0_reg;
            mask_reg <= m0_reg;
            wd1_hold_reg <= wd1_reg;
            m1_hold_reg <= m1_reg;
         end
         else if (wr_pipe_reg[`DCS_WR_B2_STG - 1])
         begin
            dq_reg <= wd1_hold_reg;
            mask_reg <= m1_hold_reg;
         end
         else
         begin
            mask_reg <= '1;
         end
         oe_reg <= wr_pipe_reg[`DCS_WR_B1_STG - 1]
                 | wr_pipe_reg[`DCS_WR_B2_STG - 1];
      end
   end

   assign lnk.dq_c = dq_reg;
   assign lnk.dq_c_oe = oe_reg;
   assign lnk.byte_mask_n = mask_reg;

   ////////////////////////////////////////////////////////////////////
   // Read beats sampled in their bus cycles, answer one cycle later
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_rd_data0 <= '0;
         o_rd_data1 <= '0;
         o_rd_valid <= 1'h0;
      end
      else
      begin
         if (rd_pipe_reg[`DCS_RD_B1_STG])
         begin
            o_rd_data0 <= lnk.dq;
         end
         if (rd_pipe_reg[`DCS_RD_B2_STG])
         begin
            o_rd_data1 <= lnk.dq;
         end
         o_rd_valid <= rd_pipe_reg[`DCS_RD_B2_STG];
      end
   end
endmodule
`default_nettype wire

// ### sim/dcs_link_monitor.sv
// Concurrent checks on the link between controller and memory ends
`timescale 1ns/1ns
`default_nettype none
module dcs_link_monitor #(
   parameter int NB = 2
)(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Link signals
   input wire logic k_rise,
   input wire logic dll_off_n,
   input wire logic load_strobe_n,
   input wire logic rw_sel,
   input wire logic [NB-1:0] byte_mask_n,
   input wire logic dq_c_oe,
   input wire logic dq_d_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////
   logic k_prev_reg; // K level one cycle back, for edge detection
   // Keep the previous K level so command cycles can be recognised
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         k_prev_reg <= 1'b0;
      else
         k_prev_reg <= k_rise;
   end
   wire k_edge = k_rise && !k_prev_reg; // True K edge cycle
   wire rd_cmd = k_edge && !load_strobe_n && rw_sel;
   wire wr_cmd = k_edge && !load_strobe_n && !rw_sel;
   wire dsel = k_edge && load_strobe_n; // Deselect, select ignored
   ////////////////////////////////////////////////////////////////////////
   sequence s_rd_beats;
      ##3 dq_d_oe [*2];
   endsequence
   sequence s_wr_beats;
      ##2 dq_c_oe [*2];
   endsequence
   property p_rd_beats;
      rd_cmd |-> s_rd_beats;
   endproperty
   property p_wr_beats;
      wr_cmd |-> s_wr_beats;
   endproperty
   property p_rd_cause;
      $rose(dq_d_oe) |-> $past(rd_cmd, 3);
   endproperty
   property p_wr_cause;
      $rose(dq_c_oe) |-> $past(wr_cmd, 2);
   endproperty
   property p_dsel_quiet;
      dsel |-> ##3 !dq_d_oe [*2];
   endproperty
   property p_one_driver;
      !(dq_d_oe && dq_c_oe);
   endproperty
   property p_turnaround;
      $fell(dq_d_oe) |-> !dq_c_oe;
   endproperty
   property p_cmd_on_k;
      !load_strobe_n |-> k_edge ##1 load_strobe_n;
   endproperty
   property p_mask_idle;
      !dq_c_oe |-> byte_mask_n == {NB{1'b1}};
   endproperty
   property p_k_runs;
      dll_off_n |-> k_rise != k_prev_reg;
   endproperty
   a_rd_beats: assert property (p_rd_beats)
      else $error("read burst beats missing");
   a_wr_beats: assert property (p_wr_beats)
      else $error("write burst beats missing");
   a_rd_cause: assert property (p_rd_cause)
      else $error("memory drove bus without read");
   a_wr_cause: assert property (p_wr_cause)
      else $error("controller drove bus without write");
   a_dsel_quiet: assert property (p_dsel_quiet)
      else $error("deselect produced read beats");
   a_one_driver: assert property (p_one_driver)
      else $error("both ends drive the data bus");
   a_turnaround: assert property (p_turnaround)
      else $error("no turnaround after read");
   a_cmd_on_k: assert property (p_cmd_on_k)
      else $error("command outside K edge cycle");
   a_mask_idle: assert property (p_mask_idle)
      else $error("mask active outside write beat");
   a_k_runs: assert property (p_k_runs)
      else $error("K stopped with DLL enabled");
endmodule
`default_nettype wire

// ### sim/dcs_tb_top.sv
// Self-checking bench joining controller and memory ends of the link
`timescale 1ns/1ns
`default_nettype none
module dcs_tb_top;
   localparam int AW = 8;
   localparam int DW = 18;
   localparam int NB = 2;
   localparam int LW = 9; // Lane width
   logic i_clk = 1'b0;
   logic i_rst_n, req_valid, req_ready, req_write, freq_change;
   logic [AW-1:0] req_addr;
   logic [DW-1:0] wd0, wd1, rd0, rd1;
   logic [NB-1:0] m0, m1;
   logic rd_valid, link_up, dll_locked, wr_abort;
   logic [DW-1:0] mem [logic [AW-1:0]]; // Expected array contents
   logic [DW-1:0] exp_q [$]; // Read beats still awaited
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int aborts = 0;
   int n;
   int abort_base = 0; // Abort pulses seen before the abort test
   ////////////////////////////////////////////////////////////////////////
   dcs_if #(.AW(AW), .DW(DW), .NB(NB)) i_dcs_if ();
   dcs_dev #(.AW(AW), .DW(DW), .NB(NB), .LOCK_CYC(8)) i_dcs_dev (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .lnk(i_dcs_if),
      .o_dll_locked(dll_locked), .o_wr_abort(wr_abort));
   dcs_ctrl #(.AW(AW), .DW(DW), .NB(NB), .PWR_CYC(4), .LOCK_CYC(8),
      .RST_CYC(2)) i_dcs_ctrl (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(req_valid),
      .o_req_ready(req_ready), .i_req_write(req_write),
      .i_req_addr(req_addr), .i_req_wdata0(wd0), .i_req_wdata1(wd1),
      .i_req_mask0_n(m0), .i_req_mask1_n(m1),
      .i_freq_change(freq_change), .o_rd_valid(rd_valid),
      .o_rd_data0(rd0), .o_rd_data1(rd1), .o_link_up(link_up),
      .lnk(i_dcs_if));
   dcs_link_monitor #(.NB(NB)) i_dcs_link_monitor (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .k_rise(i_dcs_if.k_rise),
      .dll_off_n(i_dcs_if.dll_off_n),
      .load_strobe_n(i_dcs_if.load_strobe_n), .rw_sel(i_dcs_if.rw_sel),
      .byte_mask_n(i_dcs_if.byte_mask_n), .dq_c_oe(i_dcs_if.dq_c_oe),
      .dq_d_oe(i_dcs_if.dq_d_oe));
   ////////////////////////////////////////////////////////////////////////
   // 10 MHz clock
   always #50 i_clk = ~i_clk;
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [DW-1:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   // Answers come in request order, so a queue pairs them up
   always @(negedge i_clk)
   begin
      if (wr_abort === 1'b1)
         aborts++;
      if (rd_valid === 1'b1)
      begin
         chk("rd_data0", exp_q.pop_front(), rd0);
         chk("rd_data1", exp_q.pop_front(), rd1);
      end
   end
   // Lane-wise store: a high mask bit keeps the old lane
   function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, d,
      input logic [NB-1:0] k);
      logic [DW-1:0] r;
      r = o;
      for (int l = 0; l < NB; l++)
         if (!k[l])
            r[l*LW +: LW] = d[l*LW +: LW];
      return r;
   endfunction
   // Entered at a falling edge; leaves the request up for the next call
   task automatic req(input logic w, input logic [AW-1:0] a,
      input logic [DW-1:0] d0, d1, input logic [NB-1:0] k0, k1);
      logic [AW-1:0] b;
      b = {a[AW-1:1], ~a[0]};
      {req_valid, req_write, req_addr} = {1'b1, w, a};
      {wd0, wd1, m0, m1} = {d0, d1, k0, k1};
      n = 0;
      while (req_ready !== 1'b1 && n < 50)
      begin
         @(negedge i_clk);
         n++;
      end
      @(posedge i_clk);
      if (w)
      begin
         mem[a] = merge(mem.exists(a) ? mem[a] : 'x, d0, k0);
         mem[b] = merge(mem.exists(b) ? mem[b] : 'x, d1, k1);
      end
      else
      begin
         exp_q.push_back(mem.exists(a) ? mem[a] : 'x);
         exp_q.push_back(mem.exists(b) ? mem[b] : 'x);
      end
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [AW-1:0] a);
      req(1'b0, a, '0, '0, 2'h3, 2'h3);
   endtask
   task automatic wait_up(input logic v);
      n = 0;
      while (link_up !== v && n < 400)
      begin
         @(negedge i_clk);
         n++;
      end
      chk("link_up", DW'(v), DW'(link_up));
   endtask
   task automatic done(input string name);
      req_valid = 1'b0;
      repeat (12) @(negedge i_clk);
      chk("pending", '0, DW'(exp_q.size()));
      $display("test %s done", name);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {i_rst_n, req_valid, req_write, freq_change} = '0;
      {req_addr, wd0, wd1, m0, m1} = '0;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      wait_up(1'b1);
      chk("dll_locked", 18'h1, DW'(dll_locked));
      // Even base, then odd base whose second beat lands on the even one
      req(1'b1, 8'h10, 18'h11111, 18'h22222, 2'h0, 2'h0);
      req(1'b1, 8'h21, 18'h33333, 18'h04444, 2'h0, 2'h0);
      rd(8'h10);
      rd(8'h21);
      done("burst");
      for (int m = 0; m < 4; m++)
      begin
         req(1'b1, 8'h10, 18'h2AAAA, 18'h15555, 2'(m), ~2'(m));
         rd(8'h10);
      end
      done("masks");
      abort_base = aborts;
      req(1'b1, 8'h21, 18'h0, 18'h0, 2'h3, 2'h3);
      rd(8'h21);
      done("abort");
      chk("aborts", 18'h1, DW'(aborts - abort_base));
      rd(8'h10);
      req(1'b1, 8'h20, 18'h3C3C3, 18'h0F0F0, 2'h0, 2'h2);
      rd(8'h21);
      done("turnaround");
      freq_change = 1'b1;
      wait_up(1'b0);
      freq_change = 1'b0;
      // Lock counter clears at the edge closing the first reset cycle
      @(negedge i_clk);
      chk("dll_locked", '0, DW'(dll_locked));
      wait_up(1'b1);
      chk("dll_locked", 18'h1, DW'(dll_locked));
      rd(8'h20);
      done("relock");
      tally_and_finish();
   end
endmodule
`default_nettype wire
